// >>> core/ssc_pkg.sv
package ssc_pkg;
    // timing in printed units
    localparam int CLOCK_HZ              = 50_000_000;
    localparam int FIRST_UP_TIME_MS      = 5000;
    localparam int START_MIN_MS          = 200;
    localparam int START_MAX_MS          = 5000;
    localparam int RISK_TIME_MS          = 120;
    localparam int OUTPUT_SKEW_TIME_MS   = 18;
    localparam int TEST_PULSE_WIDTH_US   = 1400;
    localparam int TEST_PULSE_PERIOD_MS  = 300;
    localparam int FEEDBACK_SETTLE_MS    = 50;
    localparam int CYCLES_PER_MS         = CLOCK_HZ / 1000;
    localparam int CYCLES_PER_US         = CLOCK_HZ / 1000000;
    // every time rounds down through the integer cycles per ms or us (exact at 50 MHz)
    localparam int FIRST_UP_CYCLES       = FIRST_UP_TIME_MS * CYCLES_PER_MS;
    localparam int START_MIN_CYCLES      = START_MIN_MS * CYCLES_PER_MS;
    localparam int START_MAX_CYCLES      = START_MAX_MS * CYCLES_PER_MS;
    localparam int TEST_PULSE_CYCLES     = TEST_PULSE_WIDTH_US * CYCLES_PER_US;
    localparam int TEST_PERIOD_CYCLES    = TEST_PULSE_PERIOD_MS * CYCLES_PER_MS;
    localparam int FEEDBACK_SETTLE_CYCLES = FEEDBACK_SETTLE_MS * CYCLES_PER_MS;
    localparam int COUNT_W               = 32;
endpackage

// >>> core/ssc_control.sv
`timescale 1ns/10ps
// Overview of operation
// - outputs off throughout power-up initialization
// - auto mode: run within 5 s
// - auto mode: transponder loss stops outputs
// - auto mode: return restarts without operator
// - manual mode: init done waits for start
// - manual run needs presence, no fault, pulse
// - manual mode: transponder loss stops outputs
// - manual mode: return needs new start
// - start high phase 200 ms to 5 s
// - overlong press ignored, fresh press needed
// - watch both contactor closed feedback contacts
// - contactors must follow commanded outputs
// - flag disagreement between both feedbacks
// - outputs off within 120 ms of loss
// - both outputs off within 18 ms
// - low test pulses while on, bounded
module ssc_control
    import ssc_pkg::*;
#(
    parameter int FIRST_UP_CYC   = FIRST_UP_CYCLES,
    parameter int START_MIN_CYC  = START_MIN_CYCLES,
    parameter int START_MAX_CYC  = START_MAX_CYCLES,
    parameter int PULSE_CYC      = TEST_PULSE_CYCLES,
    parameter int PERIOD_CYC     = TEST_PERIOD_CYCLES,
    parameter int SETTLE_CYC     = FEEDBACK_SETTLE_CYCLES
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic manual_mode,
    input  wire logic transponder_present,
    input  wire logic fault_in,
    input  wire logic start_in,
    input  wire logic first_contactor_nc,
    input  wire logic second_contactor_nc,
    output logic      redundant_safety_output_a,
    output logic      redundant_safety_output_b,
    output logic      running,
    output logic      waiting_start,
    output logic      feedback_fault
);
    // state flow: init always runs its full first-up time, even when
    // everything is ready early, so self-test time is never shortened.
    // auto mode: init -> run or stop, stop <-> run on presence.
    // manual mode: init -> wait, wait -> run on a valid press,
    // run -> stop on loss or fault, stop -> wait once clear.
    // every pin is seen two cycles late through its synchroniser;
    // the off limit leaves that delay far inside its margin.

    typedef enum logic [2:0] {ST_INIT, ST_WAIT_START, ST_RUN, ST_STOP} ssc_state_e;

    typedef struct packed {
        ssc_state_e             state;
        logic [1:0]             sync_present;
        logic [1:0]             sync_fault;
        logic [1:0]             sync_start;
        logic [1:0]             sync_mode;
        logic [1:0]             sync_fb1;
        logic [1:0]             sync_fb2;
        logic                   start_prev;
        logic                   press_valid;
        logic                   start_ok;
        logic [COUNT_W-1:0]     init_cnt;
        logic [COUNT_W-1:0]     press_cnt;
        logic [COUNT_W-1:0]     test_cnt;
        logic [COUNT_W-1:0]     fb_cnt;
        logic                   fb_fault;
        logic                   out_a;
        logic                   out_b;
    } ssc_s;

    ssc_s r;
    ssc_s next_r;

    logic present;
    logic fault;
    logic start_lvl;
    logic mode_manual;
    logic fb1;
    logic fb2;
    logic any_fault;
    logic cmd_on;
    logic test_low;

    // two-stage synchroniser; logic reads only stage 1
    function automatic logic [1:0] sync_shift(input logic [1:0] stages, input logic pin);
        sync_shift = {stages[0], pin};
    endfunction

    always_comb begin
        next_r = r;
        present     = r.sync_present[1];
        fault       = r.sync_fault[1];
        start_lvl   = r.sync_start[1];
        mode_manual = r.sync_mode[1];
        fb1         = r.sync_fb1[1];
        fb2         = r.sync_fb2[1];

        next_r.sync_present = sync_shift(r.sync_present, transponder_present);
        next_r.sync_fault   = sync_shift(r.sync_fault, fault_in);
        next_r.sync_start   = sync_shift(r.sync_start, start_in);
        next_r.sync_mode    = sync_shift(r.sync_mode, manual_mode);
        next_r.sync_fb1     = sync_shift(r.sync_fb1, first_contactor_nc);
        next_r.sync_fb2     = sync_shift(r.sync_fb2, second_contactor_nc);

        // press timing; counter saturates just past the limit
        next_r.start_prev = start_lvl;
        next_r.start_ok   = 1'b0;
        if (start_lvl && !r.start_prev) begin
            next_r.press_cnt   = '0;
            next_r.press_valid = 1'b1;
        end else if (start_lvl) begin
            if (r.press_cnt < COUNT_W'(START_MAX_CYC))
                next_r.press_cnt = r.press_cnt + 1'b1;
            else
                next_r.press_valid = 1'b0;
        end else if (r.start_prev) begin
            // release completes the low-high-low sequence; held count is one
            // below the synced high time, so both bounds land on the limits
            if (r.press_valid && r.press_cnt >= COUNT_W'(START_MIN_CYC - 1)
                    && r.press_cnt < COUNT_W'(START_MAX_CYC))
                next_r.start_ok = 1'b1;
            next_r.press_valid = 1'b0;
        end

        // contactor feedback: nc contact closed means contactor released
        // settle window hides contactor travel and test pulse echoes
        cmd_on = r.out_a | r.out_b;
        if ((fb1 != fb2) || (fb1 == cmd_on)) begin
            if (r.fb_cnt < COUNT_W'(SETTLE_CYC))
                next_r.fb_cnt = r.fb_cnt + 1'b1;
            else
                next_r.fb_fault = 1'b1;
        end else begin
            next_r.fb_cnt = '0;
            if (!cmd_on)
                next_r.fb_fault = 1'b0;
        end
        // fault stays until contacts agree with outputs off
        any_fault = fault | r.fb_fault;

        case (r.state)
            ST_INIT: begin
                // a fault at the end of init holds the block here
                next_r.init_cnt = r.init_cnt + 1'b1;
                if (r.init_cnt >= COUNT_W'(FIRST_UP_CYC - 1)) begin
                    next_r.init_cnt = r.init_cnt;
                    if (!any_fault) begin
                        if (mode_manual)
                            next_r.state = ST_WAIT_START;
                        else if (present)
                            next_r.state = ST_RUN;
                        else
                            // guard open at start-up parks in stop
                            next_r.state = ST_STOP;
                    end
                end
            end
            ST_WAIT_START: begin
                // start_ok lasts one cycle; a press ended elsewhere is lost
                if (present && !any_fault && r.start_ok)
                    next_r.state = ST_RUN;
            end
            ST_RUN: begin
                // loss and fault share one path; outputs drop on that edge
                if (!present || any_fault)
                    next_r.state = ST_STOP;
            end
            ST_STOP: begin
                if (present && !any_fault) begin
                    // manual restart always goes back through wait
                    if (mode_manual)
                        next_r.state = ST_WAIT_START;
                    else
                        next_r.state = ST_RUN;
                end
            end
            default: next_r.state = ST_INIT;
        endcase

        // test pulses only while on; width well inside period
        // pulse phase restarts on every run entry
        if (r.state == ST_RUN) begin
            if (r.test_cnt >= COUNT_W'(PERIOD_CYC - 1))
                next_r.test_cnt = '0;
            else
                next_r.test_cnt = r.test_cnt + 1'b1;
        end else begin
            next_r.test_cnt = '0;
        end
        test_low = (r.test_cnt >= COUNT_W'(PERIOD_CYC - PULSE_CYC));

        // both outputs from one state: off together, skew zero
        next_r.out_a = (next_r.state == ST_RUN) && (r.state == ST_RUN) && !test_low;
        next_r.out_b = (next_r.state == ST_RUN) && (r.state == ST_RUN) && !test_low;
        // state change into run waits one cycle so outputs rise cleanly
        if (next_r.state == ST_RUN && r.state != ST_RUN) begin
            next_r.out_a = 1'b0;
            next_r.out_b = 1'b0;
        end
    end

    // init encodes as zero, the state assignment only makes that explicit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r       <= '0;
            r.state <= ST_INIT;
        end else begin
            r <= next_r;
        end
    end

    assign redundant_safety_output_a = r.out_a;
    assign redundant_safety_output_b = r.out_b;
    assign running                   = (r.state == ST_RUN);
    assign waiting_start             = (r.state == ST_WAIT_START);
    assign feedback_fault            = r.fb_fault;
endmodule

// >>> testbench/ssc_control_asserts.sv
`timescale 1ns/10ps
module ssc_control_asserts #(parameter int FIRST_UP_CYC = 100) (
    input wire logic clock, reset_n, manual_mode, transponder_present, fault_in, running, waiting_start,
    input wire logic redundant_safety_output_a, redundant_safety_output_b, feedback_fault
);
    localparam int F = FIRST_UP_CYC - 1;
    wire a  = redundant_safety_output_a;
    wire ok = transponder_present && !fault_in && !feedback_fault;
    int  n;
    // saturates just past init so the wide compares stay cheap
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            n <= 0;
        else if (n < F + 10)
            n <= n + 1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_PAIR: assert property (a == redundant_safety_output_b) else $error("outputs differ");
    AST_INIT: assert property (n < F |-> !a && !running && !waiting_start) else $error("active in init");
    AST_AUTO: assert property (n == F && !manual_mode && ok |-> ##[0:6] running) else $error("no run");
    AST_WAIT: assert property (n == F && manual_mode && ok |-> ##[0:6] waiting_start && !a) else $error("no wait");
    AST_LOSS: assert property (!transponder_present [*4] |-> !a) else $error("late off");
    AST_FAULT: assert property (fault_in [*4] |-> !a) else $error("on with fault");
    AST_BACK: assert property ((n > F + 9 && !manual_mode && ok) [*8] |-> running) else $error("no return");
    AST_MAN: assert property ($rose(running) && manual_mode |-> $past(waiting_start)) else $error("no start");
    AST_TEST: assert property (not ((running && !a) [*5])) else $error("long pulse");
endmodule
bind ssc_control ssc_control_asserts #(.FIRST_UP_CYC(FIRST_UP_CYC)) chk_u (.*);

// >>> testbench/ssc_contactor_model.sv
`timescale 1ns/10ps
module ssc_contactor_model (
    input  wire logic clock, reset_n, drive_a, drive_b, weld,
    output logic      first_nc, second_nc
);
    logic [1:0] low_a, low_b;
    // drop-out needs two low samples, so test pulses barely show
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            low_a <= 2'h3;
            low_b <= 2'h3;
        end else begin
            low_a <= drive_a ? 2'h0 : {low_a[0], 1'b1};
            low_b <= drive_b ? 2'h0 : {low_b[0], 1'b1};
        end
    end
    assign first_nc  = &low_a;
    // welded contacts keep the mirror contact open
    assign second_nc = &low_b && !weld;
endmodule

// >>> testbench/ssc_control_bench.sv
`timescale 1ns/10ps
module ssc_control_bench;
    logic clock = 0, reset_n = 0, manual_mode = 0, tp = 1, fault_in = 0, start_in = 0, weld = 0;
    wire  nc1, nc2, oa, ob, running, waiting_start, feedback_fault;
    int   error_cnt = 0, checks = 0, cyc = 0;
    always #10 clock = ~clock;
    always @(posedge clock) if (++cyc == 2000) end_of_test(1);
    // shortened timing; pulse well inside the period, min below max
    localparam int FIRST_UP = 100;
    localparam int MIN_CYC  = 10;
    localparam int MAX_CYC  = 50;
    localparam int PULSE    = 3;
    localparam int PERIOD   = 40;
    localparam int SETTLE   = 8;
    ssc_control #(.FIRST_UP_CYC(FIRST_UP), .START_MIN_CYC(MIN_CYC), .START_MAX_CYC(MAX_CYC), .PULSE_CYC(PULSE),
        .PERIOD_CYC(PERIOD), .SETTLE_CYC(SETTLE)) dut_u (.clock, .reset_n, .manual_mode, .transponder_present(tp),
        .fault_in, .start_in,
        .first_contactor_nc(nc1), .second_contactor_nc(nc2), .redundant_safety_output_a(oa),
        .redundant_safety_output_b(ob), .running, .waiting_start, .feedback_fault);
    ssc_contactor_model fb_u (.clock, .reset_n, .drive_a(oa), .drive_b(ob), .weld, .first_nc(nc1), .second_nc(nc2));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic v, input string m);
        checks++;
        if (v !== 1'b1) error_cnt++;
        if (v !== 1'b1) $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic end_of_test(input int e);
        error_cnt += e;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic boot(input logic m);
        reset_n = 0;
        manual_mode = m;
        tick(12);
        reset_n = 1;
        tick(FIRST_UP + 10);
    endtask
    task automatic press(input int n);
        start_in = 1;
        tick(n);
        start_in = 0;
        tick(6);
    endtask
    task automatic t_auto;
        int lows;
        boot(0);
        chk(running && oa && ob, "auto run");
        lows = 0;
        // one full period in run holds exactly one pulse, on both outputs
        repeat (PERIOD) begin
            tick(1);
            if (!oa)
                lows++;
            chk(oa === ob, "outputs apart");
        end
        chk(lows == PULSE && running, "test pulse width");
        tp = 0;
        tick(4);
        chk(!oa && !ob && !running, "auto stop");
        tp = 1;
        tick(6);
        chk(running, "auto return");
    endtask
    task automatic t_manual;
        boot(1);
        chk(waiting_start && !oa && !running, "no wait");
        press(MIN_CYC - 1);
        chk(!running, "short press ran");
        press(MAX_CYC + 1);
        chk(!running, "long press ran");
        press(MIN_CYC);
        chk(running && oa && ob, "valid press");
        tp = 0;
        tick(4);
        chk(!oa && !running, "manual stop");
        tp = 1;
        tick(20);
        chk(!running && !oa && waiting_start, "restarted alone");
    endtask
    task automatic t_fault;
        press(MAX_CYC);
        chk(running, "fresh press after long");
        fault_in = 1;
        tick(4);
        chk(!oa && !running, "fault stop");
        fault_in = 0;
        weld = 1;
        tick(20);
        chk(feedback_fault && !oa, "weld unseen");
        press(20);
        chk(!running, "ran with weld");
    endtask
    initial begin
        t_auto;
        t_manual;
        t_fault;
        end_of_test(0);
    end
endmodule
